// ### common/pmv_pkg.sv
// Constants and types of the power mode sequencer
package pmv_pkg;
  localparam int unsigned TB_CNT_P0  = 32000;
  localparam int unsigned TB_CNT_P1  = 64000;
  localparam int unsigned TB_CNT_P2  = 160000;
  localparam int unsigned TB_CNT_P3  = 400000;
  localparam int unsigned WAKE_TICKS = 4096;
  localparam logic [5:0]  RUN_DIV       = 6'h02;
  localparam logic [5:0]  SLOW_DIV_BASE = 6'h04;

  localparam logic [7:0] IDX_CLKCTL  = 8'h29;
  localparam logic [7:0] IDX_MISC    = 8'h20;
  localparam logic [7:0] IDX_STAT    = 8'h2c;
  localparam logic [7:0] CLKCTL_RST  = 8'h01;
  localparam logic [7:0] MISC_RST    = 8'h00;
  localparam int         CLK_FLAG    = 0;
  localparam int         CLK_WAKE_EN = 1;
  localparam int         CLK_TB_LO   = 2;
  localparam int         MISC_DIV_LO = 0;
  localparam int         MISC_SLOW   = 2;
  localparam int         MISC_WDG    = 3;
  localparam int         STAT_SLOW   = 5;

  localparam logic [15:0] VEC_TOP        = 16'hfffe;
  localparam logic [3:0]  SLOT_RESET     = 4'h0;
  localparam logic [3:0]  SLOT_TRAP      = 4'h1;
  localparam logic [15:0] HALT_EXIT_MASK = 16'h00f9;

  typedef enum logic [4:0] {
    PM_RUN   = 5'h01,
    PM_HALT  = 5'h02,
    PM_AHALT = 5'h04,
    PM_WAIT  = 5'h08,
    PM_WAKE  = 5'h10
  } pmv_mode_t;

  function automatic logic [15:0] pmv_vec_of(input logic [3:0] slot);
    return VEC_TOP - {11'h000, slot, 1'b0};
  endfunction
endpackage

// ### common/pmv_link_if.sv
// Signals between the sequencer, its priority encoder and its divider
interface pmv_link_if;
  logic [15:0] req;
  logic [3:0]  slot;
  logic        valid;
  logic        slow;
  logic [1:0]  div_sel;
  logic        tick;
  modport prio (input req, output slot, output valid);
  modport div  (input slow, input div_sel, output tick);
  modport ctrl (output req, output slow, output div_sel, input slot, input valid, input tick);
endinterface

// ### hdl/pmv_prio.sv
// Fixed priority encoder over the request slots
module pmv_prio
  import pmv_pkg::*;
(
  pmv_link_if.prio lnk
);
  always_comb begin
    lnk.valid = 1'b0;
    lnk.slot  = SLOT_RESET;
    for (int i = 15; i >= 0; i--) begin
      if (lnk.req[i]) begin
        lnk.valid = 1'b1;
        lnk.slot  = 4'(i);
      end
    end
  end
endmodule

// ### hdl/pmv_clk_div.sv
// CPU clock prescaler producing one tick per CPU cycle
module pmv_clk_div
  import pmv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  pmv_link_if.div  lnk
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } pmv_div_st_t;

  pmv_div_st_t state_ff;
  pmv_div_st_t nxt_state;

  function automatic logic [5:0] div_ratio(input logic slow, input logic [1:0] sel);
    return slow ? (SLOW_DIV_BASE << sel) : RUN_DIV;
  endfunction

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.tick = 1'b0;
    if (state_ff.cnt >= div_ratio(lnk.slow, lnk.div_sel) - 6'h01) begin
      nxt_state.cnt  = 6'h00;
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.cnt = state_ff.cnt + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign lnk.tick = state_ff.tick;
endmodule

// ### hdl/pmv_power_seq.sv
// Power mode sequencer with interrupt vectoring and AHB-Lite registers
// How it works
// - Time base and clock security share vector fff8, both wake from halt
// - Four external group vectors from fff6 down to fff0
// - Serial and two timer vectors ffec, ffea, ffe8; serial cannot wake halt
// - After reset run mode with oscillator divided by 2
// - Halt enters standard halt if wake enable is 0, active-halt if 1
// - Entering either halt mode clears the global interrupt mask
// - Halt ends only on reset or halt-exit interrupt, then 4096 CPU cycles
// - After the delay the CPU serves the waking interrupt or reset vector
// - Standard halt stops oscillator, processing and peripheral clocks
// - Halt with watchdog active may reset, per watchdog-in-halt option
// - Leaving standard halt restarts oscillator and waits 4096 cycles
// - Active-halt keeps only oscillator and time base running
// - Active-halt entry with watchdog active gives no reset
// - Time base interrupt always ends active-halt
// - Wait stops only the CPU and clears the global interrupt mask
// - Any interrupt or reset ends wait and goes to its routine
// - Slow mode divides by 4, 8, 16 or 32 by two select bits
// - Wait while slow gives slow-wait with the reduced clock
// - Wake enable is bit 1 of the clock control register, index 29
// - Serving an interrupt sets the global interrupt mask
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
module pmv_power_seq
  import pmv_pkg::*;
#(
  parameter int unsigned TB_P0 = TB_CNT_P0,
  parameter int unsigned TB_P1 = TB_CNT_P1,
  parameter int unsigned TB_P2 = TB_CNT_P2,
  parameter int unsigned TB_P3 = TB_CNT_P3
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        halt_instr,
  input  wire logic        wait_for_irq_instr,
  input  wire logic        trap_instr,
  input  wire logic        imask,
  input  wire logic        watchdog_active,
  input  wire logic        css_irq,
  input  wire logic [3:0]  ext_irq_pin,
  input  wire logic        spi_irq,
  input  wire logic        tima_irq,
  input  wire logic        timb_irq,
  input  wire logic        sci_irq,
  input  wire logic        ee_irq,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_run,
  output logic             tb_run,
  output logic             imask_clr,
  output logic             imask_set,
  output logic             vec_valid,
  output logic      [15:0] vec_addr,
  output logic             wdg_reset_req
);
  typedef struct packed {
    pmv_mode_t   mode;
    logic [18:0] tb_cnt;
    logic [1:0]  tb_sel;
    logic [1:0]  tb_sel_act;
    logic        wake_en;
    logic        tb_flag;
    logic        slow;
    logic [1:0]  div_sel;
    logic        wdg_opt;
    logic [12:0] wake_cnt;
    logic        reset_pend;
    logic        trap_pend;
    logic [3:0]  ext_s1;
    logic [3:0]  ext_s2;
    logic        ap_wr;
    logic [7:0]  ap_idx;
    logic [31:0] rdata;
    logic        rdy;
    logic        resp;
    logic        cpu_en;
    logic        per_en;
    logic        osc_on;
    logic        tb_on;
    logic        iclr;
    logic        iset;
    logic        vvalid;
    logic [15:0] vaddr;
    logic        wdg_rst;
  } pmv_seq_st_t;

  localparam pmv_seq_st_t ST_RST = '{
    mode: PM_RUN, tb_sel: CLKCTL_RST[3:2], tb_sel_act: CLKCTL_RST[3:2],
    wake_en: CLKCTL_RST[CLK_WAKE_EN], tb_flag: CLKCTL_RST[CLK_FLAG],
    slow: MISC_RST[MISC_SLOW], div_sel: MISC_RST[1:0], wdg_opt: MISC_RST[MISC_WDG],
    reset_pend: 1'b1, rdy: 1'b1, cpu_en: 1'b1, per_en: 1'b1, osc_on: 1'b1, tb_on: 1'b1,
    default: '0};

  pmv_seq_st_t state_ff;
  pmv_seq_st_t nxt_state;
  pmv_link_if  lnk ();
  logic        halt_exit;
  logic        tb_wrap;

  pmv_prio u_prio (
    .lnk (lnk.prio)
  );

  pmv_clk_div u_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .lnk     (lnk.div)
  );

  function automatic logic [18:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'h0:    return 19'(TB_P0);
      2'h1:    return 19'(TB_P1);
      2'h2:    return 19'(TB_P2);
      default: return 19'(TB_P3);
    endcase
  endfunction

  // Request slots: bit n is vector fffe minus 2n
  assign lnk.req = {2'b00, ee_irq, sci_irq, timb_irq, tima_irq, spi_irq, 1'b0,
                    state_ff.ext_s2,
                    (state_ff.tb_flag & state_ff.wake_en) | css_irq, 1'b0,
                    state_ff.trap_pend, state_ff.reset_pend};
  assign lnk.slow    = state_ff.slow;
  assign lnk.div_sel = state_ff.div_sel;
  assign halt_exit   = |(lnk.req & HALT_EXIT_MASK);
  assign tb_wrap     = state_ff.tb_on && (state_ff.tb_cnt >= tb_period(state_ff.tb_sel_act) - 19'h1);

  always_comb begin
    nxt_state         = state_ff;
    nxt_state.iclr    = 1'b0;
    nxt_state.iset    = 1'b0;
    nxt_state.vvalid  = 1'b0;
    nxt_state.wdg_rst = 1'b0;
    nxt_state.ap_wr   = 1'b0;
    nxt_state.ext_s1  = ext_irq_pin;
    nxt_state.ext_s2  = state_ff.ext_s1;

    // Address phase: capture write, answer read one cycle later
    if (hready && hsel && htrans[1]) begin
      nxt_state.ap_idx = haddr[9:2];
      nxt_state.rdata  = 32'h0000_0000;
      if (haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0 || hsize != 3'h2) begin
        nxt_state.ap_idx = 8'h00;
      end else if (hwrite) begin
        nxt_state.ap_wr = 1'b1;
      end else if (haddr[9:2] == IDX_CLKCTL) begin
        nxt_state.rdata   = {28'h0, state_ff.tb_sel, state_ff.wake_en, state_ff.tb_flag};
        nxt_state.tb_flag = 1'b0;
      end else if (haddr[9:2] == IDX_MISC) begin
        nxt_state.rdata = {28'h0, state_ff.wdg_opt, state_ff.slow, state_ff.div_sel};
      end else if (haddr[9:2] == IDX_STAT) begin
        nxt_state.rdata = {26'h0, state_ff.slow & (state_ff.mode == PM_WAIT), state_ff.mode};
      end
    end

    // Data phase of a write
    if (state_ff.ap_wr) begin
      if (state_ff.ap_idx == IDX_CLKCTL) begin
        nxt_state.tb_sel  = hwdata[CLK_TB_LO +: 2];
        nxt_state.wake_en = hwdata[CLK_WAKE_EN];
      end else if (state_ff.ap_idx == IDX_MISC) begin
        nxt_state.div_sel = hwdata[MISC_DIV_LO +: 2];
        nxt_state.slow    = hwdata[MISC_SLOW];
        nxt_state.wdg_opt = hwdata[MISC_WDG];
      end
    end

    // Time base; a new period takes effect at the wrap
    if (tb_wrap) begin
      nxt_state.tb_cnt     = 19'h0;
      nxt_state.tb_sel_act = state_ff.tb_sel;
      nxt_state.tb_flag    = 1'b1;
    end else if (state_ff.tb_on) begin
      nxt_state.tb_cnt = state_ff.tb_cnt + 19'h1;
    end

    case (state_ff.mode)
      PM_RUN: begin
        if (halt_instr) begin
          if (!state_ff.wake_en && watchdog_active && !state_ff.wdg_opt) begin
            nxt_state.wdg_rst = 1'b1;
          end else begin
            nxt_state.mode = state_ff.wake_en ? PM_AHALT : PM_HALT;
            nxt_state.iclr = 1'b1;
          end
        end else if (wait_for_irq_instr) begin
          nxt_state.mode = PM_WAIT;
          nxt_state.iclr = 1'b1;
        end else if (lnk.valid && lnk.tick && !state_ff.vvalid && !state_ff.iset &&
                     (lnk.slot <= SLOT_TRAP || !imask)) begin
          nxt_state.vvalid = 1'b1;
          nxt_state.iset   = 1'b1;
          nxt_state.vaddr  = pmv_vec_of(lnk.slot);
          if (lnk.slot == SLOT_RESET) begin
            nxt_state.reset_pend = 1'b0;
          end else if (lnk.slot == SLOT_TRAP) begin
            nxt_state.trap_pend = 1'b0;
          end
        end
      end
      PM_HALT, PM_AHALT: begin
        if (halt_exit) begin
          nxt_state.mode     = PM_WAKE;
          nxt_state.wake_cnt = 13'h0;
        end
      end
      PM_WAIT: begin
        if (lnk.valid) begin
          nxt_state.mode = PM_RUN;
        end
      end
      PM_WAKE: begin
        if (lnk.tick) begin
          if (state_ff.wake_cnt == 13'(WAKE_TICKS - 1)) begin
            nxt_state.mode = PM_RUN;
          end else begin
            nxt_state.wake_cnt = state_ff.wake_cnt + 13'h1;
          end
        end
      end
      default: nxt_state.mode = PM_RUN;
    endcase

    if (trap_instr) begin
      nxt_state.trap_pend = 1'b1;
    end

    // Clock gating follows the coming mode
    nxt_state.cpu_en = (nxt_state.mode == PM_RUN);
    nxt_state.per_en = (nxt_state.mode == PM_RUN) || (nxt_state.mode == PM_WAIT);
    nxt_state.osc_on = (nxt_state.mode != PM_HALT);
    nxt_state.tb_on  = (nxt_state.mode != PM_HALT);
    nxt_state.rdy    = 1'b1;
    nxt_state.resp   = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hrdata        = state_ff.rdata;
  assign hreadyout     = state_ff.rdy;
  assign hresp         = state_ff.resp;
  assign cpu_clk_en    = state_ff.cpu_en;
  assign periph_clk_en = state_ff.per_en;
  assign osc_run       = state_ff.osc_on;
  assign tb_run        = state_ff.tb_on;
  assign imask_clr     = state_ff.iclr;
  assign imask_set     = state_ff.iset;
  assign vec_valid     = state_ff.vvalid;
  assign vec_addr      = state_ff.vaddr;
  assign wdg_reset_req = state_ff.wdg_rst;

  property p_halt_entry;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_RUN && halt_instr && state_ff.wake_en) |=>
      (state_ff.mode == PM_AHALT && imask_clr && !wdg_reset_req && tb_run && !periph_clk_en);
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("active-halt entry wrong");

  property p_halt_clr;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(state_ff.mode == PM_HALT) |-> imask_clr ##1 !imask_clr;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("mask not cleared on halt");

  property p_halt_off;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_HALT) |-> (!osc_run && !cpu_clk_en && !periph_clk_en && !tb_run);
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("clock running in halt");

  property p_wdg_halt;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_RUN && halt_instr && !state_ff.wake_en && watchdog_active && !state_ff.wdg_opt)
      |=> (wdg_reset_req && state_ff.mode == PM_RUN);
  endproperty
  a_wdg_halt: assert property (p_wdg_halt) else $error("no watchdog reset on halt");

  property p_wake_len;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_WAKE && nxt_state.mode == PM_RUN) |-> (state_ff.wake_cnt == 13'(WAKE_TICKS - 1));
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake delay not 4096 cycles");

  property p_tb_exit;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_AHALT && state_ff.tb_flag && state_ff.wake_en) |=> (state_ff.mode == PM_WAKE);
  endproperty
  a_tb_exit: assert property (p_tb_exit) else $error("time base did not end active-halt");

  property p_spi_stay;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_HALT && spi_irq && !halt_exit) |=> (state_ff.mode == PM_HALT);
  endproperty
  a_spi_stay: assert property (p_spi_stay) else $error("serial interrupt woke halt");

  property p_wait;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.mode == PM_RUN && !halt_instr && wait_for_irq_instr) |=>
      (imask_clr && !cpu_clk_en && periph_clk_en && osc_run);
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");

  property p_vec_mask;
    @(posedge sys_clk) disable iff (!rst_b)
    vec_valid |-> (imask_set && vec_addr[0]== 1'b0 && vec_addr >= 16'hffe0) ##1 !vec_valid;
  endproperty
  a_vec_mask: assert property (p_vec_mask) else $error("service without mask set");

  property p_first_vec;
    @(posedge sys_clk) disable iff (!rst_b)
    (state_ff.reset_pend && nxt_state.vvalid) |=> (vec_addr == VEC_TOP);
  endproperty
  a_first_vec: assert property (p_first_vec) else $error("reset vector not served first");

  c_ahalt_wake: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff.mode == PM_AHALT ##1 state_ff.mode == PM_WAKE);
  c_halt_ext: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff.mode == PM_HALT && |state_ff.ext_s2);
  c_slow_wait: cover property (@(posedge sys_clk) disable iff (!rst_b)
    state_ff.mode == PM_WAIT && state_ff.slow);
  c_wdg: cover property (@(posedge sys_clk) disable iff (!rst_b) wdg_reset_req);
endmodule

// ### verification/pmv_core_model.sv
// CPU core model: mask bit, instruction pulses and vector capture
module pmv_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  input  wire logic        imask_set,
  input  wire logic        imask_clr,
  output logic             imask,
  output logic             halt_instr,
  output logic             wait_for_irq_instr,
  output logic             trap_instr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        imask_ff;
  logic        iret_req;
  logic [15:0] vec_q[$];

  initial begin
    halt_instr = 1'b0;
    wait_for_irq_instr = 1'b0;
    trap_instr = 1'b0;
    iret_req = 1'b0;
  end

  assign imask = imask_ff;

  // Mask set on entry to a routine, cleared by halt/wait entry or return
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      imask_ff <= 1'b1;
    end else if (imask_set) begin
      imask_ff <= 1'b1;
    end else if (imask_clr || iret_req) begin
      imask_ff <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (vec_valid) begin
      vec_q.push_back(vec_addr);
    end
  end

  // Kind 0 halt, 1 wait, other trap; one cycle wide
  task automatic pulse(input int kind);
    @(posedge sys_clk);
    case (kind)
      0: halt_instr <= 1'b1;
      1: wait_for_irq_instr <= 1'b1;
      default: trap_instr <= 1'b1;
    endcase
    @(posedge sys_clk);
    halt_instr <= 1'b0;
    wait_for_irq_instr <= 1'b0;
    trap_instr <= 1'b0;
  endtask

  task automatic iret();
    @(posedge sys_clk);
    iret_req <= 1'b1;
    @(posedge sys_clk);
    iret_req <= 1'b0;
  endtask
endmodule

// ### verification/power_mode_and_irq_vectoring_tb.sv
// Self-checking bench for the power mode sequencer
module power_mode_and_irq_vectoring_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] A_CLK  = {22'h0, pmv_pkg::IDX_CLKCTL, 2'b00};
  localparam logic [31:0] A_MISC = {22'h0, pmv_pkg::IDX_MISC, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, pmv_pkg::IDX_STAT, 2'b00};
  localparam int          WAKE_LEN = 4096 * 2;
  localparam logic [15:0] VTAB [10] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
                                        16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4};

  logic        sys_clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        watchdog_active;
  logic [9:0]  src;
  wire         css_irq     = src[0];
  wire  [3:0]  ext_irq_pin = src[4:1];
  wire         spi_irq     = src[5];
  wire         tima_irq    = src[6];
  wire         timb_irq    = src[7];
  wire         sci_irq     = src[8];
  wire         ee_irq      = src[9];
  logic        imask;
  logic        halt_instr;
  logic        wait_for_irq_instr;
  logic        trap_instr;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        osc_run;
  logic        tb_run;
  logic        imask_clr;
  logic        imask_set;
  logic        vec_valid;
  logic [15:0] vec_addr;
  logic        wdg_reset_req;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  pmv_power_seq #(.TB_P0(40), .TB_P1(80), .TB_P2(200), .TB_P3(500)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .halt_instr(halt_instr), .wait_for_irq_instr(wait_for_irq_instr),
    .trap_instr(trap_instr), .imask(imask), .watchdog_active(watchdog_active), .css_irq(css_irq),
    .ext_irq_pin(ext_irq_pin), .spi_irq(spi_irq), .tima_irq(tima_irq), .timb_irq(timb_irq),
    .sci_irq(sci_irq), .ee_irq(ee_irq), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
    .tb_run(tb_run), .imask_clr(imask_clr), .imask_set(imask_set), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .wdg_reset_req(wdg_reset_req));

  pmv_core_model core_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .vec_valid(vec_valid), .vec_addr(vec_addr), .imask_set(imask_set),
    .imask_clr(imask_clr), .imask(imask), .halt_instr(halt_instr),
    .wait_for_irq_instr(wait_for_irq_instr), .trap_instr(trap_instr));

  always #12.5 sys_clk = ~sys_clk;

  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer of size sz, word by default; address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic pop_vec(input logic [15:0] e);
    while (core_u.vec_q.size() == 0) @(posedge sys_clk);
    chk("vector", {16'h0, e}, {16'h0, core_u.vec_q.pop_front()});
  endtask

  // Source cleared, synchroniser flushed, then return from routine
  task automatic isr_end(input int i);
    src[i] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    core_u.iret();
  endtask

  initial begin
    int n;
    int m;
    sys_clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    watchdog_active = 1'b0;
    src = 10'h000;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    pop_vec(16'hfffe);
    rd_chk("stat", A_STAT, 32'h01);
    bus(1'b0, A_CLK, 32'h0, 3'h0);
    chk("byte_rd", 32'h0, rd);
    rd_chk("clkctl", A_CLK, 32'h01);
    rd_chk("misc", A_MISC, 32'h00);
    bus(1'b1, A_STAT, 32'hff);
    rd_chk("stat_ro", A_STAT, 32'h01);
    rd_chk("unmapped", 32'h100, 32'h0);
    // Halt with watchdog on and option clear: reset request, no halt
    watchdog_active <= 1'b1;
    core_u.pulse(0);
    n = 0;
    repeat (4) begin
      @(posedge sys_clk);
      if (wdg_reset_req === 1'b1) n++;
    end
    chk("wdg_req", 32'h1, n);
    rd_chk("stat", A_STAT, 32'h01);
    // Standard halt, option set
    bus(1'b1, A_MISC, 32'h08);
    core_u.pulse(0);
    repeat (2) @(posedge sys_clk);
    chk("clk_en", 32'h0, {28'h0, cpu_clk_en, periph_clk_en, osc_run, tb_run});
    chk("imask", 32'h0, {31'h0, imask});
    rd_chk("stat", A_STAT, 32'h02);
    src[5] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd_chk("stat", A_STAT, 32'h02);
    src[1] <= 1'b1;
    m = 0;
    while (osc_run !== 1'b1) begin
      @(posedge sys_clk);
      m++;
    end
    chk("osc_restart", 32'h1, (m <= 6));
    n = 0;
    while (cpu_clk_en !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake_len", 32'h1, (n >= WAKE_LEN - 4 && n <= WAKE_LEN + 4));
    pop_vec(16'hfff6);
    src[5] <= 1'b0;
    isr_end(1);
    // Active-halt with watchdog on: no reset, time base wakes
    bus(1'b1, A_MISC, 32'h00);
    // Clear the flag just after a wrap so active-halt lasts most of a period
    bus(1'b0, A_CLK, 32'h0);
    do bus(1'b0, A_CLK, 32'h0); while (rd[0] !== 1'b1);
    bus(1'b1, A_CLK, 32'h02);
    core_u.pulse(0);
    n = 0;
    repeat (2) begin
      @(posedge sys_clk);
      if (wdg_reset_req === 1'b1) n++;
    end
    chk("wdg_req", 32'h0, n);
    chk("clk_en", 32'h3, {28'h0, cpu_clk_en, periph_clk_en, osc_run, tb_run});
    rd_chk("stat", A_STAT, 32'h04);
    pop_vec(16'hfff8);
    bus(1'b1, A_CLK, 32'h00);
    bus(1'b0, A_CLK, 32'h0);
    core_u.iret();
    // Wait while slow
    bus(1'b1, A_MISC, 32'h04);
    core_u.pulse(1);
    repeat (2) @(posedge sys_clk);
    chk("clk_wait", 32'h2, {29'h0, cpu_clk_en, periph_clk_en, imask});
    rd_chk("stat", A_STAT, 32'h28);
    src[6] <= 1'b1;
    pop_vec(16'hffea);
    src[6] <= 1'b0;
    bus(1'b1, A_MISC, 32'h00);
    // All sources pending under mask; trap first, then fixed order
    src <= 10'h3ff;
    core_u.pulse(2);
    pop_vec(16'hfffc);
    repeat (4) @(posedge sys_clk);
    core_u.iret();
    for (int i = 0; i < 10; i++) begin
      pop_vec(VTAB[i]);
      isr_end(i);
    end
    test_done();
  end
endmodule
